// [oswc_pkg.sv]
/*
 * Constants, field layout and types for the oscillator switch control block.
 * Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package oswc_pkg;

   // ---------------------------------------------------------------
   // bus and register map
   // ---------------------------------------------------------------
   localparam int          AXI_AW             = 8;
   localparam logic [7:0]  OSC_CTRL_ADDR      = 8'h00;
   localparam logic [1:0]  RESP_OKAY          = 2'h0;
   localparam logic [1:0]  RESP_SLVERR        = 2'h2;

   // ---------------------------------------------------------------
   // oscillator_control field positions
   // ---------------------------------------------------------------
   localparam int          CUR_LSB            = 12;
   localparam int          REQ_LSB            = 8;
   localparam int          FREEZE_BIT         = 7;
   localparam int          LOCK_BIT           = 5;
   localparam int          FAIL_BIT           = 3;
   localparam int          START_BIT          = 0;
   localparam logic [31:0] OSC_CTRL_RW_MASK   = 32'h0000_0789;
   localparam logic        FREEZE_RST         = 1'b0;
   localparam logic        FAIL_RST           = 1'b0;

   // ---------------------------------------------------------------
   // source encoding
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SRC_FAST_RC      = 3'h0,
      SRC_FAST_RC_PLL  = 3'h1,
      SRC_PRIMARY      = 3'h2,
      SRC_PRIMARY_PLL  = 3'h3,
      SRC_SECONDARY    = 3'h4,
      SRC_LOW_POWER_RC = 3'h5,
      SRC_FAST_RC_DIV16 = 3'h6,
      SRC_FAST_RC_DIVN = 3'h7
   } oswc_src_t;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int          CLK_PERIOD_NS      = 40;
   localparam int          PLL_START_NS       = 2000;
   localparam int          PLL_START_CYC      = (PLL_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // switch sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SW_IDLE = 2'h1,
      SW_WAIT = 2'h2
   } oswc_sw_state_t;

endpackage

// [oswc_sw_if.sv]
/*
 * Carrier between the register front end and the switch sequencer.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps
interface oswc_sw_if;
   import oswc_pkg::*;
   logic       start;
   logic [2:0] target;
   logic [2:0] init_src;
   logic       src_ready;
   logic [2:0] current;
   logic       busy;
   logic       done;
   logic       reject;

   modport ctl (output start, output target, output init_src, output src_ready,
                input current, input busy, input done, input reject);
   modport seq (input start, input target, input init_src, input src_ready,
                output current, output busy, output done, output reject);
endinterface

// [oswc_switch.sv]
/*
 * Clock switch sequencer: accepts a switch request, refuses the forbidden
 * pair of PLL modes, waits for the new source and then adopts it.
 * Assumes start is a one-cycle pulse issued only while busy is low.
 */
`timescale 1ns/100ps
module oswc_switch
   import oswc_pkg::*;
(
   input  wire logic SYS_CLK,
   input  wire logic SYS_RST,
   oswc_sw_if.seq    sw
);

   oswc_sw_state_t state_r;
   logic [2:0]     target_r;
   logic [2:0]     current_r;
   logic           done_r;
   logic           reject_r;
   logic           forbidden;

   // ---------------------------------------------------------------
   // forbidden pair check
   // ---------------------------------------------------------------
   // pll to pll refused
   assign forbidden = ((current_r == SRC_FAST_RC_PLL) && (sw.target == SRC_PRIMARY_PLL)) ||
                      ((current_r == SRC_PRIMARY_PLL) && (sw.target == SRC_FAST_RC_PLL));

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         state_r  <= SW_IDLE;
         target_r <= 3'h0;
         done_r   <= 1'b0;
         reject_r <= 1'b0;
      end else begin
         done_r   <= 1'b0;
         reject_r <= 1'b0;
         case (state_r)
            SW_IDLE: begin
               if (sw.start && forbidden) begin
                  reject_r <= 1'b1;
               end else if (sw.start) begin
                  target_r <= sw.target;
                  state_r  <= SW_WAIT;
               end
            end
            SW_WAIT: begin
               if (sw.src_ready) begin
                  done_r  <= 1'b1;
                  state_r <= SW_IDLE;
               end
            end
            default: begin
               state_r <= SW_IDLE;
            end
         endcase
      end
   end

   // source in use updated on completion
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         current_r <= sw.init_src;
      end else if ((state_r == SW_WAIT) && sw.src_ready) begin
         current_r <= target_r;
      end
   end

   assign sw.current = current_r;
   assign sw.busy    = (state_r == SW_WAIT);
   assign sw.done    = done_r;
   assign sw.reject  = reject_r;

   AST_NO_PLL_PAIR: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (sw.start && forbidden && (state_r == SW_IDLE)) |=> reject_r && $stable(current_r)
         ##1 (state_r == SW_IDLE) && $stable(current_r))
      else $error("forbidden pll switch was not refused");

endmodule

// [oswc_top.sv]
/*
 * Oscillator switch control: one control register on AXI4-Lite with the
 * source in use, the requested source, configuration freeze, pll lock and
 * clock fail status, plus the switch sequencer and pll start-up timer.
 * Assumes all inputs are synchronous to SYS_CLK and AXI4-Lite rules are kept.
 */
// Behaviour
// - requested source bits 10:8 writable, reset value from configuration input.
// - both fields use the eight-way source encoding of the package.
// - lock bit 5 high when a pll mode is in use and the pll is locked or start-up timer expired.
// - direct switch between the two pll modes is refused.
`timescale 1ns/100ps
module oswc_top
   import oswc_pkg::*;
#(
   parameter int PLL_START_CYCLES = PLL_START_CYC
)
(
   input  wire logic                     SYS_CLK,
   input  wire logic                     SYS_RST,
   input  wire logic [oswc_pkg::AXI_AW-1:0] S_AXI_AWADDR,
   input  wire logic                     S_AXI_AWVALID,
   output logic                          S_AXI_AWREADY,
   input  wire logic [31:0]              S_AXI_WDATA,
   input  wire logic [3:0]               S_AXI_WSTRB,
   input  wire logic                     S_AXI_WVALID,
   output logic                          S_AXI_WREADY,
   output logic [1:0]                    S_AXI_BRESP,
   output logic                          S_AXI_BVALID,
   input  wire logic                     S_AXI_BREADY,
   input  wire logic [oswc_pkg::AXI_AW-1:0] S_AXI_ARADDR,
   input  wire logic                     S_AXI_ARVALID,
   output logic                          S_AXI_ARREADY,
   output logic [31:0]                   S_AXI_RDATA,
   output logic [1:0]                    S_AXI_RRESP,
   output logic                          S_AXI_RVALID,
   input  wire logic                     S_AXI_RREADY,
   input  wire logic [2:0]               CFG_SOURCE,
   input  wire logic                     CLOCK_MONITOR_CONFIG_BIT,
   input  wire logic                     PLL_LOCKED,
   input  wire logic                     SRC_READY,
   input  wire logic                     CLOCK_FAIL_IN,
   output logic [2:0]                    CLK_SEL,
   output logic                          PLL_EN
);

   oswc_sw_if sw ();

   logic [AXI_AW-1:0] awaddr_r;
   logic [31:0]       wdata_r;
   logic [3:0]        wstrb_r;
   logic              aw_got_r;
   logic              w_got_r;
   logic              do_write;
   logic              wr_hit;
   logic [2:0]        req_r;
   logic              freeze_r;
   logic              fail_r;
   logic              start_r;
   logic              lock_r;
   logic [15:0]       timer_r;
   logic              pll_on;
   logic              frozen;
   logic [31:0]       rd_word;

   // ---------------------------------------------------------------
   // switch sequencer
   // ---------------------------------------------------------------
   oswc_switch u_switch (
      .SYS_CLK (SYS_CLK),
      .SYS_RST (SYS_RST),
      .sw      (sw)
   );

   assign sw.start     = start_r;
   assign sw.target    = req_r;
   assign sw.init_src  = CFG_SOURCE;
   assign sw.src_ready = SRC_READY;

   // ---------------------------------------------------------------
   // axi4-lite write channel
   // ---------------------------------------------------------------
   assign do_write = aw_got_r && w_got_r && !S_AXI_BVALID;
   assign wr_hit   = (awaddr_r == OSC_CTRL_ADDR);

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         awaddr_r      <= '0;
         wdata_r       <= 32'h0;
         wstrb_r       <= 4'h0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= RESP_OKAY;
      end else begin
         S_AXI_AWREADY <= !aw_got_r && !(S_AXI_AWVALID && S_AXI_AWREADY);
         S_AXI_WREADY  <= !w_got_r && !(S_AXI_WVALID && S_AXI_WREADY);
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            awaddr_r <= S_AXI_AWADDR;
            aw_got_r <= 1'b1;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            wdata_r <= S_AXI_WDATA;
            wstrb_r <= S_AXI_WSTRB;
            w_got_r <= 1'b1;
         end
         if (do_write) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID  <= 1'b0;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // control fields
   // ---------------------------------------------------------------
   assign frozen = freeze_r && CLOCK_MONITOR_CONFIG_BIT;

   // requested source, power-on value from configuration
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         req_r <= CFG_SOURCE;
      end else if (do_write && wr_hit && wstrb_r[1] && !frozen && !sw.busy) begin
         req_r <= wdata_r[REQ_LSB +: 3];
      end
   end

   // freeze sticks while the monitor configuration bit is set
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         freeze_r <= FREEZE_RST;
      end else if (do_write && wr_hit && wstrb_r[0] && !frozen) begin
         freeze_r <= wdata_r[FREEZE_BIT];
      end
   end

   // switch request pulse, one at a time
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         start_r <= 1'b0;
      end else begin
         start_r <= do_write && wr_hit && wstrb_r[0] && wdata_r[START_BIT] && !frozen &&
                    !sw.busy && !start_r;
      end
   end

   // clock fail flag: hardware set beats software clear
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         fail_r <= FAIL_RST;
      end else if (CLOCK_FAIL_IN) begin
         fail_r <= 1'b1;
      end else if (do_write && wr_hit && wstrb_r[0] && !wdata_r[FAIL_BIT]) begin
         fail_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // pll enable, start-up timer and lock
   // ---------------------------------------------------------------
   // pll modes by encoding
   assign pll_on = (sw.current == SRC_FAST_RC_PLL) || (sw.current == SRC_PRIMARY_PLL);

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         timer_r <= 16'h0;
      end else if (!pll_on) begin
         timer_r <= 16'h0;
      end else if (timer_r != 16'(PLL_START_CYCLES)) begin
         timer_r <= timer_r + 16'h1;
      end
   end

   // lock when a pll mode is in use and locked or timer expired
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         lock_r <= 1'b0;
      end else begin
         lock_r <= pll_on && (PLL_LOCKED || (timer_r == 16'(PLL_START_CYCLES)));
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         CLK_SEL <= 3'h0;
         PLL_EN  <= 1'b0;
      end else begin
         CLK_SEL <= sw.current;
         PLL_EN  <= pll_on;
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite read channel
   // ---------------------------------------------------------------
   // current source read-only
   assign rd_word = {16'h0, 1'b0, sw.current, 1'b0, req_r, freeze_r, 1'b0, lock_r,
                     1'b0, fail_r, 2'h0, sw.busy};

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0;
         S_AXI_RRESP   <= RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b1;
         S_AXI_RDATA   <= (S_AXI_ARADDR == OSC_CTRL_ADDR) ? rd_word : 32'h0;
         S_AXI_RRESP   <= (S_AXI_ARADDR == OSC_CTRL_ADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID  <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end else if (!S_AXI_RVALID) begin
         S_AXI_ARREADY <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_CUR_ONLY_ON_DONE: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      !$stable(sw.current) |-> sw.done)
      else $error("source in use changed without a completed switch");

   AST_REQ_FROM_CFG: assert property (@(posedge SYS_CLK)
      (SYS_RST ##1 !SYS_RST) |-> req_r == $past(CFG_SOURCE))
      else $error("requested source not loaded from configuration");

   AST_PLL_ENCODING: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (sw.current == SRC_PRIMARY_PLL) [*2] |-> PLL_EN && (CLK_SEL == 3'h3))
      else $error("primary with pll not driving pll enable");

   AST_LOCK_SET: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (pll_on && PLL_LOCKED) |=> lock_r)
      else $error("lock not reported while pll locked");

   AST_LOCK_CLEAR: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (!pll_on || (!PLL_LOCKED && timer_r < 16'(PLL_START_CYCLES))) |=> !lock_r)
      else $error("lock reported while pll off or starting");

   AST_NO_DIRECT_PLL: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (sw.current == SRC_FAST_RC_PLL) |=> (sw.current != SRC_PRIMARY_PLL))
      else $error("direct switch between pll modes performed");

   AST_RESERVED_ZERO: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      S_AXI_RVALID |-> (S_AXI_RDATA & ~(OSC_CTRL_RW_MASK | 32'h0000_7020)) == 32'h0)
      else $error("unimplemented bit read as one");

   AST_FAIL_SET_WINS: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      CLOCK_FAIL_IN |=> fail_r ##1 (fail_r || $past(do_write)))
      else $error("clock fail event lost");

endmodule

// [oswc_top_tb.sv]
/*
 * Self-checking bench for oswc_top: register reset values and access kinds,
 * the source switch sequence with the forbidden pll pair, lock status,
 * clock fail flag, freeze and unmapped access over AXI4-Lite.
 * Assumes oswc_pkg is compiled first; the start-up count is shortened to 4.
 */
`timescale 1ns/100ps
module oswc_top_tb;
   import oswc_pkg::*;

   // ---------------------------------------------------------------
   // signals and state
   // ---------------------------------------------------------------
   localparam logic [2:0] TGT [12] = '{3'h1, 3'h3, 3'h0, 3'h3, 3'h1, 3'h0,
                                        3'h2, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
   logic        sys_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdat;
   logic [3:0]  wstrb;
   logic [1:0]  bresp_o, rresp_o, bresp_s, rresp_s;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [31:0] rdata_o;
   logic [2:0]  cfg, clk_sel, cur, req, t;
   logic        mon, locked, src_rdy, fail_in, pll_en, frz, fl, lk, refused;
   int          fails, n_compared, seed;

   oswc_top #(.PLL_START_CYCLES(4)) i_dut (
      .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp_o), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata_o), .S_AXI_RRESP(rresp_o), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .CFG_SOURCE(cfg), .CLOCK_MONITOR_CONFIG_BIT(mon),
      .PLL_LOCKED(locked), .SRC_READY(src_rdy), .CLOCK_FAIL_IN(fail_in),
      .CLK_SEL(clk_sel), .PLL_EN(pll_en));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic is_pll(input logic [2:0] s);
      return (s == SRC_FAST_RC_PLL) || (s == SRC_PRIMARY_PLL);
   endfunction

   function automatic logic [31:0] exp_word(input logic busy);
      return {17'h0, cur, 1'b0, req, frz, 1'b0, lk, 1'b0, fl, 2'h0, busy};
   endfunction

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic hang();
      fails++;
      $display("mismatch at %0t: wait timed out", $time);
      end_sim();
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int   n;
      logic pa, pw, pb;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      pb = 1'b1;
      for (n = 0; n < 64 && pb; n++) begin
         @(posedge sys_clk);
         if (!pa && !pw && bvalid) begin
            pb = 1'b0;
            bresp_s = bresp_o;
            bready <= 1'b0;
         end
         if (pa && awready) begin
            pa = 1'b0;
            awvalid <= 1'b0;
         end
         if (pw && wready) begin
            pw = 1'b0;
            wvalid <= 1'b0;
         end
      end
      if (pb) hang();
   endtask

   task automatic rd(input logic [7:0] a);
      int   n;
      logic pa, pb;
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      pa = 1'b1;
      pb = 1'b1;
      for (n = 0; n < 64 && pb; n++) begin
         @(posedge sys_clk);
         if (pa && arready) begin
            pa = 1'b0;
            arvalid <= 1'b0;
         end else if (!pa && rvalid) begin
            pb = 1'b0;
            rdat = rdata_o;
            rresp_s = rresp_o;
            rready <= 1'b0;
         end
      end
      if (pb) hang();
   endtask

   task automatic do_reset();
      logic [2:0] c;
      sys_rst <= 1'b1;
      do c = 3'($urandom); while (is_pll(c));
      cfg <= c;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      #1;
      cur = cfg;
      req = cfg;
      frz = 1'b0;
      fl = 1'b0;
      lk = 1'b0;
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, mon, locked, src_rdy, fail_in} = '0;
      {awaddr, araddr, wdata, wstrb, cfg} = '0;
      wstrb = 4'hf;
      sys_rst = 1'b1;
      fails = 0;
      n_compared = 0;
      seed = $urandom(41);
      do_reset();
      rd(OSC_CTRL_ADDR);
      check(rdat, exp_word(1'b0));
      $display("test reset values done");

      wr(OSC_CTRL_ADDR, 32'h0000_7f76);
      req = 3'h7;
      check({30'h0, bresp_s}, {30'h0, RESP_OKAY});
      rd(OSC_CTRL_ADDR);
      check(rdat, exp_word(1'b0));
      $display("test access kinds done");

      wr(8'h04, 32'h0000_0201);
      check({30'h0, bresp_s}, {30'h0, RESP_SLVERR});
      rd(8'h04);
      check(rdat, 32'h0);
      check({30'h0, rresp_s}, {30'h0, RESP_SLVERR});
      rd(OSC_CTRL_ADDR);
      check(rdat, exp_word(1'b0));
      $display("test unmapped access done");

      for (int i = 0; i < 12; i++) begin
         t = TGT[i];
         locked <= 1'($urandom);
         refused = (cur == 3'h1 && t == 3'h3) || (cur == 3'h3 && t == 3'h1);
         wr(OSC_CTRL_ADDR, {21'h0, t, 8'h01});
         req = t;
         rd(OSC_CTRL_ADDR);
         check(rdat, exp_word(!refused));
         if (!refused) begin
            wr(OSC_CTRL_ADDR, {21'h0, t ^ 3'h1, 8'h00});
            repeat ($urandom_range(4, 0)) @(posedge sys_clk);
            src_rdy <= 1'b1;
            @(posedge sys_clk);
            src_rdy <= 1'b0;
            cur = t;
            lk = is_pll(cur) && locked;
            rd(OSC_CTRL_ADDR);
            check(rdat, exp_word(1'b0));
         end
         repeat (12) @(posedge sys_clk);
         lk = is_pll(cur);
         rd(OSC_CTRL_ADDR);
         check(rdat, exp_word(1'b0));
         check({28'h0, pll_en, clk_sel}, {28'h0, is_pll(cur), cur});
      end
      $display("test source switching done");

      @(posedge sys_clk);
      fail_in <= 1'b1;
      @(posedge sys_clk);
      fail_in <= 1'b0;
      fl = 1'b1;
      rd(OSC_CTRL_ADDR);
      check(rdat, exp_word(1'b0));
      wr(OSC_CTRL_ADDR, {21'h0, req, 8'h00});
      fl = 1'b0;
      rd(OSC_CTRL_ADDR);
      check(rdat, exp_word(1'b0));
      $display("test clock fail flag done");

      mon <= 1'b1;
      wr(OSC_CTRL_ADDR, {21'h0, req, 8'h80});
      frz = 1'b1;
      wr(OSC_CTRL_ADDR, {21'h0, ~req, 8'h01});
      rd(OSC_CTRL_ADDR);
      check(rdat, exp_word(1'b0));
      $display("test freeze done");

      mon <= 1'b0;
      do_reset();
      rd(OSC_CTRL_ADDR);
      check(rdat, exp_word(1'b0));
      check({29'h0, clk_sel}, {29'h0, cfg});
      $display("test second reset done");
      end_sim();
   end
endmodule
